// ### core/exec_consts.svh
/*
 Named constants for the byte and bit instruction execution core:
 widths, special file addresses, phase counts and flag bit positions.
 Assumes it is included by bare name from the package and design files.
*/
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define DATA_W 8
`define ADDR_W 7
`define BIT_W 3
`define FILE_DEPTH 128

// Special file addresses
`define ADDR_TIMER 7'h01
`define ADDR_PCL 7'h02
`define ADDR_PORT 7'h06

// Four oscillator periods per instruction cycle
`define PHASE_W 2
`define PHASE_FIRST 2'h0
`define PHASE_LAST 2'h3
`define PHASE_STEP 2'h1

`define BYTE_ZERO 8'h00
`define CARRY_POS 8
`define DIGIT_POS 4

`endif

// ### core/exec_pkg.sv
/*
 Types shared by the execution core: operation codes, sequencer states
 and the packed state record of the top module.
 Assumes exec_consts.svh is on the include path.
*/
`include "exec_consts.svh"

package exec_pkg;

	typedef logic [`DATA_W-1:0] byte_t;

	typedef enum logic [2:0] {
		add_immediate_op = 3'h0,
		and_immediate_op = 3'h1,
		add_file_op = 3'h2,
		and_file_op = 3'h3,
		bit_clear_op = 3'h4,
		bit_set_op = 3'h5,
		move_file_op = 3'h6
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_FILLER = 3'h4
	} seq_state_t;

	typedef struct packed {
		seq_state_t seq;
		logic [`PHASE_W-1:0] phase;
		op_kind_t op;
		logic [`ADDR_W-1:0] addr;
		logic [`BIT_W-1:0] bitSel;
		byte_t literal;
		logic destFile;
		byte_t wReg;
		logic carry;
		logic digitCarry;
		logic zero;
		byte_t portLatch;
		byte_t pinMeta;
		byte_t pinSync;
		byte_t [`FILE_DEPTH-1:0] fileMem;
		logic ready;
		logic done;
		logic prescalerClear;
		logic pcLoad;
		byte_t pcLow;
		logic writeStrobe;
		logic [`ADDR_W-1:0] writeAddr;
		byte_t writeData;
		byte_t peekData;
	} core_state_t;

endpackage

// ### core/byte_alu.sv
/*
 Combinational datapath for the byte and bit instructions: sum, AND,
 move and single-bit set or clear, with carry, digit carry and zero.
 Assumes the caller picks the operand (file or pins) and commits results.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"

module byte_alu (
	// Operation
	input wire exec_pkg::op_kind_t op,
	input wire logic destFile,
	input wire logic [`BIT_W-1:0] bitSel,
	// Operands
	input wire exec_pkg::byte_t wVal,
	input wire exec_pkg::byte_t operand,
	input wire exec_pkg::byte_t literal,
	// Results
	output exec_pkg::byte_t result,
	output logic carryOut,
	output logic digitOut,
	output logic zeroOut,
	output logic updArith,
	output logic updZero,
	output logic toFile
);

	exec_pkg::byte_t addend;
	exec_pkg::byte_t bitRes;
	logic [`DATA_W:0] sum;
	logic [`DIGIT_POS:0] lowSum;

	genvar i;
	generate
		for (i = 0; i < `DATA_W; i++) begin : g_bit
			// Only the selected bit moves; the rest pass through
			assign bitRes[i] = (bitSel == `BIT_W'(i)) ?
				(op == exec_pkg::bit_set_op) : operand[i];
		end
	endgenerate

	always_comb begin
		addend = (op == exec_pkg::add_immediate_op ||
			op == exec_pkg::and_immediate_op) ? literal : operand;
		sum = {1'b0, wVal} + {1'b0, addend};
		lowSum = {1'b0, wVal[`DIGIT_POS-1:0]} +
			{1'b0, addend[`DIGIT_POS-1:0]};
		result = sum[`DATA_W-1:0];
		updArith = 1'b0;
		updZero = 1'b0;
		toFile = 1'b0;
		case (op)
			exec_pkg::add_immediate_op: begin
				updArith = 1'b1;
				updZero = 1'b1;
			end
			exec_pkg::add_file_op: begin
				updArith = 1'b1;
				updZero = 1'b1;
				toFile = destFile;
			end
			exec_pkg::and_immediate_op: begin
				result = wVal & literal;
				updZero = 1'b1;
			end
			exec_pkg::and_file_op: begin
				result = wVal & operand;
				updZero = 1'b1;
				toFile = destFile;
			end
			exec_pkg::move_file_op: begin
				result = operand;
				updZero = 1'b1;
				toFile = destFile;
			end
			exec_pkg::bit_clear_op, exec_pkg::bit_set_op: begin
				// Flags untouched by bit operations
				result = bitRes;
				toFile = 1'b1;
			end
			default: begin
				result = `BYTE_ZERO;
			end
		endcase
		carryOut = sum[`CARRY_POS];
		digitOut = lowSum[`DIGIT_POS];
		zeroOut = (result == `BYTE_ZERO);
	end

endmodule

`default_nettype wire

// ### core/byte_bit_instruction_exec.sv
/*
 Execution core for add, AND, move and bit set/clear instructions on a
 working register and a 128-byte file held in flip-flops, with one I/O
 port, the timer count register and the low program counter byte.
 Assumes the clock is the oscillator; one instruction cycle is four clocks.
 Assumes requests come from logic on the same clock; only the port pins
 are asynchronous and pass two flip-flops before anything reads them.
*/
// Operation
// - Read-modify-write of the I/O port takes pin levels, not latch.
// - File write to timer count clears prescaler when prescaler assigned.
// - Program counter change costs a second cycle spent idle.
// - Add immediate: W plus literal into W; carry, digit carry, zero.
// - AND with file: destination bit picks W or file; zero only.
// - Add with file: destination picks W or file; all three flags.
// - Bit clear forces selected file bit to zero; flags unchanged.
// - AND immediate: W and literal into W; zero flag only.
// - Bit set forces selected file bit to one; flags unchanged.
// - Each instruction cycle spans four oscillator clocks.

`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"

module byte_bit_instruction_exec (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Instruction request
	input wire logic opValid,
	input wire exec_pkg::op_kind_t opKind,
	input wire logic [`ADDR_W-1:0] fileAddr,
	input wire logic [`BIT_W-1:0] bitSel,
	input wire exec_pkg::byte_t literal,
	input wire logic destFile,
	output logic ready,
	output logic done,
	// Timer prescaler
	input wire logic prescalerAssigned,
	output logic prescalerClear,
	// Program counter
	output logic pcLoad,
	output exec_pkg::byte_t pcLow,
	// I/O port
	input wire exec_pkg::byte_t portPins,
	output exec_pkg::byte_t portLatch,
	// Core state
	output exec_pkg::byte_t wReg,
	output logic carry,
	output logic digitCarry,
	output logic zero,
	// File write trace
	output logic writeStrobe,
	output logic [`ADDR_W-1:0] writeAddr,
	output exec_pkg::byte_t writeData,
	// File peek
	input wire logic [`ADDR_W-1:0] peekAddr,
	output exec_pkg::byte_t peekData
);

	exec_pkg::core_state_t s_r;
	exec_pkg::core_state_t s_nxt;
	exec_pkg::byte_t operand;
	exec_pkg::byte_t aluResult;
	logic aluCarry;
	logic aluDigit;
	logic aluZero;
	logic updArith;
	logic updZero;
	logic toFile;
	logic lastPhase;

	// The port address reads the synchronised pins, never the latch
	always_comb begin
		if (s_r.addr == `ADDR_PORT) begin
			operand = s_r.pinSync;
		end else begin
			operand = s_r.fileMem[s_r.addr];
		end
	end

	assign lastPhase = (s_r.phase == `PHASE_LAST);

	byte_alu u_alu (
		.op(s_r.op),
		.destFile(s_r.destFile),
		.bitSel(s_r.bitSel),
		.wVal(s_r.wReg),
		.operand(operand),
		.literal(s_r.literal),
		.result(aluResult),
		.carryOut(aluCarry),
		.digitOut(aluDigit),
		.zeroOut(aluZero),
		.updArith(updArith),
		.updZero(updZero),
		.toFile(toFile)
	);

	// One copy of the whole state, filled below and registered at once
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.prescalerClear = 1'b0;
		s_nxt.pcLoad = 1'b0;
		s_nxt.writeStrobe = 1'b0;
		// Pins are asynchronous: only the second flop is ever read
		s_nxt.pinMeta = portPins;
		s_nxt.pinSync = s_r.pinMeta;
		// Peek mirrors what an instruction would read
		if (peekAddr == `ADDR_PORT) begin
			s_nxt.peekData = s_r.pinSync;
		end else begin
			s_nxt.peekData = s_r.fileMem[peekAddr];
		end
		case (s_r.seq)
			exec_pkg::ST_IDLE: begin
				// Requests while busy are dropped without notice
				if (opValid) begin
					s_nxt.seq = exec_pkg::ST_EXEC;
					s_nxt.phase = `PHASE_FIRST;
					s_nxt.op = opKind;
					s_nxt.addr = fileAddr;
					s_nxt.bitSel = bitSel;
					s_nxt.literal = literal;
					s_nxt.destFile = destFile;
					s_nxt.ready = 1'b0;
				end
			end
			exec_pkg::ST_EXEC: begin
				if (!lastPhase) begin
					s_nxt.phase = s_r.phase + `PHASE_STEP;
				end else begin
					// Commit at the end of the fourth clock
					if (updArith) begin
						s_nxt.carry = aluCarry;
						s_nxt.digitCarry = aluDigit;
					end
					if (updZero) begin
						s_nxt.zero = aluZero;
					end
					s_nxt.seq = exec_pkg::ST_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.ready = 1'b1;
					if (toFile) begin
						s_nxt.writeStrobe = 1'b1;
						s_nxt.writeAddr = s_r.addr;
						s_nxt.writeData = aluResult;
						if (s_r.addr == `ADDR_PORT) begin
							// Pins may differ from latch; latch takes result
							s_nxt.portLatch = aluResult;
						end else begin
							s_nxt.fileMem[s_r.addr] = aluResult;
						end
						// Bit operations count too: they always write back
						if (s_r.addr == `ADDR_TIMER && prescalerAssigned) begin
							s_nxt.prescalerClear = 1'b1;
						end
						if (s_r.addr == `ADDR_PCL) begin
							// Fetched word is stale; spend one idle cycle
							s_nxt.pcLoad = 1'b1;
							s_nxt.pcLow = aluResult;
							s_nxt.seq = exec_pkg::ST_FILLER;
							s_nxt.phase = `PHASE_FIRST;
							s_nxt.done = 1'b0;
							s_nxt.ready = 1'b0;
						end
					end else if (updArith || updZero) begin
						// Unknown codes leave W alone and only report done
						s_nxt.wReg = aluResult;
					end
				end
			end
			exec_pkg::ST_FILLER: begin
				// Second cycle does nothing but burn four clocks
				if (!lastPhase) begin
					s_nxt.phase = s_r.phase + `PHASE_STEP;
				end else begin
					s_nxt.seq = exec_pkg::ST_IDLE;
					s_nxt.done = 1'b1;
					s_nxt.ready = 1'b1;
				end
			end
			default: begin
				// Illegal state codes fall back to idle
				s_nxt.seq = exec_pkg::ST_IDLE;
				s_nxt.ready = 1'b1;
			end
		endcase
	end

	// File, latch and flags all clear with the rest of the state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.seq <= exec_pkg::ST_IDLE;
			s_r.ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Every output is a state bit, so none of them is combinational
	assign ready = s_r.ready;
	assign done = s_r.done;
	assign prescalerClear = s_r.prescalerClear;
	assign pcLoad = s_r.pcLoad;
	assign pcLow = s_r.pcLow;
	assign portLatch = s_r.portLatch;
	assign wReg = s_r.wReg;
	assign carry = s_r.carry;
	assign digitCarry = s_r.digitCarry;
	assign zero = s_r.zero;
	assign writeStrobe = s_r.writeStrobe;
	assign writeAddr = s_r.writeAddr;
	assign writeData = s_r.writeData;
	assign peekData = s_r.peekData;

endmodule

`default_nettype wire

// ### dv/byte_bit_exec_assertions.sv
/* Checker: request timing, filler cycle, prescaler clear, results.
 Assumes it is bound to the core from the bench top. */
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"
module byte_bit_exec_assertions (
	// Clock, reset, request
	input wire logic clock,
	input wire logic reset_n,
	input wire logic opValid,
	input wire exec_pkg::op_kind_t opKind,
	input wire exec_pkg::byte_t literal,
	input wire logic ready,
	input wire logic done,
	// Side effects
	input wire logic prescalerAssigned,
	input wire logic prescalerClear,
	input wire logic pcLoad,
	input wire exec_pkg::byte_t pcLow,
	input wire exec_pkg::byte_t portLatch,
	input wire logic writeStrobe,
	input wire logic [`ADDR_W-1:0] writeAddr,
	input wire exec_pkg::byte_t writeData,
	// Core state
	input wire exec_pkg::byte_t wReg,
	input wire logic carry,
	input wire logic digitCarry,
	input wire logic zero
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	exec_pkg::op_kind_t kindR;
	exec_pkg::byte_t wTake;
	exec_pkg::byte_t litTake;
	// Operands kept from the take edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			kindR <= exec_pkg::add_immediate_op;
			wTake <= 8'h00;
			litTake <= 8'h00;
		end else if (opValid && ready) begin
			kindR <= opKind;
			wTake <= wReg;
			litTake <= literal;
		end
	end
	sequence busy_run;
		!ready [*4];
	endsequence
	sequence filler_run;
		!ready ##1 (!ready && !done) [*3] ##1 (done && ready);
	endsequence
	a_take_busy: assert property (
		opValid && ready |=> busy_run ##1 (done || pcLoad)) else $error("busy");
	a_done_pulse: assert property (
		done |-> ready ##1 !done) else $error("done pulse");
	a_filler_idle: assert property (
		pcLoad |-> filler_run) else $error("filler");
	a_pc_trace: assert property (pcLoad |-> writeStrobe &&
		writeAddr == `ADDR_PCL && pcLow == writeData) else $error("pc");
	a_timer_clear: assert property (prescalerClear == (writeStrobe &&
		writeAddr == `ADDR_TIMER && $past(prescalerAssigned)))
		else $error("prescaler");
	a_port_latch: assert property (writeStrobe &&
		writeAddr == `ADDR_PORT |-> portLatch == writeData) else $error("latch");
	a_bit_flags: assert property (done && (kindR == exec_pkg::bit_set_op ||
		kindR == exec_pkg::bit_clear_op) |-> $stable({carry, digitCarry, zero}))
		else $error("bit flags");
	a_and_flags: assert property (done && (kindR == exec_pkg::and_file_op ||
		kindR == exec_pkg::and_immediate_op) |-> $stable({carry, digitCarry}))
		else $error("and flags");
	a_add_imm: assert property (done &&
		kindR == exec_pkg::add_immediate_op |-> zero == (wReg == 8'h00) &&
		{carry, wReg} == {1'b0, wTake} + {1'b0, litTake} &&
		digitCarry == ((wTake[3:0] + litTake[3:0]) > 5'h0f)) else $error("add");
	a_and_imm: assert property (done &&
		kindR == exec_pkg::and_immediate_op |-> wReg == (wTake & litTake))
		else $error("and");
endmodule
`default_nettype wire

// ### dv/byte_bit_instruction_exec_tb_top.sv
/* Bench top: random instruction stream against a reference model, results
 queued by the driver. Assumes the core and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"
module byte_bit_instruction_exec_tb_top;
	logic clock = 1'b0, reset_n = 1'b0, opValid = 1'b0, destFile = 1'b0;
	logic prescalerAssigned = 1'b0, ready, done, prescalerClear, pcLoad;
	logic carry, digitCarry, zero, writeStrobe;
	exec_pkg::op_kind_t opKind = exec_pkg::add_immediate_op;
	logic [6:0] fileAddr = 7'h00, peekAddr = 7'h00, writeAddr;
	logic [2:0] bitSel = 3'h0;
	exec_pkg::byte_t literal = 8'h00, portPins = 8'h00, w = 8'h00, lat = 8'h00;
	exec_pkg::byte_t pcLow, portLatch, wReg, writeData, peekData;
	exec_pkg::byte_t mem [128] = '{default: 8'h00};
	logic c = 1'b0, hc = 1'b0, z = 1'b0;
	logic [18:0] q [$];
	logic [18:0] got;
	logic [6:0] addrs [6] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h33, 7'h7f};
	integer seed = 34686, bad_count = 0, n_checks = 0, i;

	byte_bit_instruction_exec uut (.clock, .reset_n, .opValid, .opKind,
		.fileAddr, .bitSel, .literal, .destFile, .ready, .done,
		.prescalerAssigned, .prescalerClear, .pcLoad, .pcLow, .portPins,
		.portLatch, .wReg, .carry, .digitCarry, .zero, .writeStrobe,
		.writeAddr, .writeData, .peekAddr, .peekData);

	always #25 clock = ~clock;

	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic run_op(input logic [2:0] kd, input logic [6:0] a);
		logic [31:0] rnd;
		exec_pkg::byte_t src, r;
		logic [8:0] s;
		int n;
		rnd = $random(seed);
		src = (a == `ADDR_PORT) ? rnd[15:8] : mem[a];
		src = (kd < 3'h2) ? rnd[7:0] : src;
		r = src;
		case (kd)
			3'h0, 3'h2: begin
				s = {1'b0, w} + {1'b0, src};
				r = s[7:0];
				c = s[8];
				hc = (w[3:0] + src[3:0]) > 5'h0f;
			end
			3'h1, 3'h3: r = w & src;
			3'h4: r = src & ~(8'h01 << rnd[18:16]);
			3'h5: r = src | (8'h01 << rnd[18:16]);
			default: r = src;
		endcase
		if (kd < 3'h4 || kd == 3'h6)
			z = (r == 8'h00);
		if (kd >= 3'h2 && (rnd[19] || kd == 3'h4 || kd == 3'h5)) begin
			if (a == `ADDR_PORT)
				lat = r;
			else
				mem[a] = r;
		end else
			w = r;
		q.push_back({w, c, hc, z, lat});
		opKind <= exec_pkg::op_kind_t'(kd);
		fileAddr <= a;
		literal <= rnd[7:0];
		portPins <= rnd[15:8];
		bitSel <= rnd[18:16];
		destFile <= rnd[19];
		prescalerAssigned <= rnd[20];
		opValid <= 1'b1;
		@(posedge clock);
		// Held one more edge while busy: must be ignored
		@(posedge clock);
		opValid <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		if (done !== 1'b1)
			bad_count++;
		@(posedge clock);
	endtask

	always @(negedge clock) begin
		if (done === 1'b1) begin
			got = {wReg, carry, digitCarry, zero, portLatch};
			check(got, q.pop_front());
		end
	end

	initial begin
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		$display("test done: reset");
		for (i = 0; i < 7; i++)
			run_op(i[2:0], `ADDR_PORT);
		for (i = 0; i < 150; i++)
			run_op(3'($unsigned($random(seed)) % 7),
				addrs[$unsigned($random(seed)) % 6]);
		$display("test done: instruction stream");
		for (i = 0; i < 6; i++) begin
			peekAddr <= addrs[i];
			@(posedge clock);
			@(negedge clock);
			check(peekData, (addrs[i] == `ADDR_PORT) ? portPins : mem[addrs[i]]);
			@(posedge clock);
		end
		$display("test done: file contents");
		give_verdict;
	end

	// Stream needs about 1000 clocks
	initial begin
		#(50 * 4000);
		bad_count++;
		give_verdict;
	end
endmodule

bind byte_bit_instruction_exec byte_bit_exec_assertions chk (.clock,
	.reset_n, .opValid, .opKind, .literal, .ready, .done, .prescalerAssigned,
	.prescalerClear, .pcLoad, .pcLow, .portLatch, .writeStrobe, .writeAddr,
	.writeData, .wReg, .carry, .digitCarry, .zero);
`default_nettype wire
